// ==== agc_bank_consts.vh ====
`ifndef AGC_BANK_CONSTS_VH
`define AGC_BANK_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_BIAS_DMIC 8'h19
`define OFS_AGC_A 8'h1A
`define OFS_AGC_B 8'h1B
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BIAS_DMIC 8'h00
`define RST_AGC_A 8'h00
`define RST_AGC_B 8'hFE
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIAS_HI 7
`define BIAS_LO 6
`define ROUTE_HI 5
`define ROUTE_LO 4
`define AGC_EN_BIT 7
`define TGT_HI 6
`define TGT_LO 4
`define ATK_HI 3
`define ATK_LO 2
`define DEC_HI 1
`define DEC_LO 0
`define MAXG_HI 7
`define MAXG_LO 1
// ----------------------------------------
// Codes
// ----------------------------------------
`define BIAS_OFF 2'h0
`define BIAS_2V0 2'h1
`define BIAS_2V5 2'h2
`define BIAS_SUPPLY 2'h3
`define ROUTE_BOTH 2'h0
`define ROUTE_LEFT 2'h1
`define ROUTE_RIGHT 2'h2
`define MAXG_CLAMP 7'h76
`endif

// ==== reg_cell.v ====
`timescale 1ns/1ps
`default_nettype none
module reg_cell #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] WMASK = 8'hFF
) (
  input wire clk_sys_in,
  input wire rst_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] q_out
);
  // Only writable bits take new data; the rest hold
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      q_out <= RESET_VAL;
    end else if (wr_in) begin
      q_out <= (wdata_in & WMASK) | (q_out & ~WMASK);
    end
  end
endmodule
`default_nettype wire

// ==== left_agc_mic_bias_output_config.v ====
// How it works
// - Bias field picks off, 2.0V, 2.5V or supply; resets to off.
// - Digital mics on with route 00: both channels from digital mics.
// - Route 01: left from digital mic, right from its converter.
// - Route 10: left from its converter, right from digital mic.
// - Bias bits 3..0 take zeros only; reset value undefined, held zero here.
// - Left gain control enable bit, resets off.
// - Three-bit target level, codes 0..6 to -5.5..-24 dB, resets 000.
// - Attack code picks 8, 11, 16 or 20 ms, resets 00.
// - Decay code picks 100, 200, 400 or 500 ms, resets 00.
// - Listed times hold only without double rate audio.
// - Seven-bit max gain, 0.5 dB steps, resets all ones.
// - Codes above 59 dB clamp to 59.5 dB.
`timescale 1ns/1ps
`default_nettype none
`include "agc_bank_consts.vh"
module left_agc_mic_bias_output_config (
  input wire clk_sys_in,
  input wire rst_in,
  input wire wr_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  input wire dmic_enable_in,
  input wire double_rate_audio_in,
  output reg [1:0] mic_bias_output_out,
  output reg left_from_dmic_out,
  output reg right_from_dmic_out,
  output reg agc_enable_out,
  output reg [2:0] target_code_out,
  output reg [1:0] attack_code_out,
  output reg [1:0] decay_code_out,
  output reg times_exact_out,
  output reg [6:0] max_gain_code_out
);
  // ----------------------------------------
  // Register cells
  // ----------------------------------------
  wire [7:0] bias_q;
  wire [7:0] agc_a_q;
  wire [7:0] agc_b_q;
  wire wr_bias;
  wire wr_agc_a;
  wire wr_agc_b;
  reg dmic_meta_q;
  reg dmic_sync_q;
  reg dra_meta_q;
  reg dra_sync_q;
  wire [1:0] bias_field;
  wire [1:0] route_field;
  wire agc_en_field;
  wire [2:0] target_field;
  wire [1:0] attack_field;
  wire [1:0] decay_field;
  wire [6:0] max_gain_field;
  reg left_dmic_d;
  reg right_dmic_d;
  reg [6:0] max_gain_d;
  reg [7:0] rdata_d;

  // Unmapped writes match no strobe and are lost
  assign wr_bias = wr_en_in && (addr_in == `OFS_BIAS_DMIC);
  assign wr_agc_a = wr_en_in && (addr_in == `OFS_AGC_A);
  assign wr_agc_b = wr_en_in && (addr_in == `OFS_AGC_B);

  // Low four bits fixed at zero; writes there are dropped
  reg_cell #(.RESET_VAL(`RST_BIAS_DMIC), .WMASK(8'hF0)) u_bias (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .wr_in(wr_bias),
    .wdata_in(wdata_in),
    .q_out(bias_q)
  );
  reg_cell #(.RESET_VAL(`RST_AGC_A), .WMASK(8'hFF)) u_agc_a (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .wr_in(wr_agc_a),
    .wdata_in(wdata_in),
    .q_out(agc_a_q)
  );
  reg_cell #(.RESET_VAL(`RST_AGC_B), .WMASK(8'hFF)) u_agc_b (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .wr_in(wr_agc_b),
    .wdata_in(wdata_in),
    .q_out(agc_b_q)
  );

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  assign bias_field = bias_q[`BIAS_HI:`BIAS_LO];
  assign route_field = bias_q[`ROUTE_HI:`ROUTE_LO];
  assign agc_en_field = agc_a_q[`AGC_EN_BIT];
  assign target_field = agc_a_q[`TGT_HI:`TGT_LO];
  assign attack_field = agc_a_q[`ATK_HI:`ATK_LO];
  assign decay_field = agc_a_q[`DEC_HI:`DEC_LO];
  assign max_gain_field = agc_b_q[`MAXG_HI:`MAXG_LO];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Only the second stage feeds logic; the first may be metastable
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dmic_meta_q <= 1'b0;
      dmic_sync_q <= 1'b0;
    end else begin
      dmic_meta_q <= dmic_enable_in;
      dmic_sync_q <= dmic_meta_q;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dra_meta_q <= 1'b0;
      dra_sync_q <= 1'b0;
    end else begin
      dra_meta_q <= double_rate_audio_in;
      dra_sync_q <= dra_meta_q;
    end
  end

  // ----------------------------------------
  // Next-value logic
  // ----------------------------------------
  // Reserved code 11 gives neither channel a digital mic
  always @* begin
    left_dmic_d = 1'b0;
    right_dmic_d = 1'b0;
    case (route_field)
      `ROUTE_BOTH: begin
        left_dmic_d = dmic_sync_q;
        right_dmic_d = dmic_sync_q;
      end
      `ROUTE_LEFT: begin
        left_dmic_d = dmic_sync_q;
      end
      `ROUTE_RIGHT: begin
        right_dmic_d = dmic_sync_q;
      end
      default: begin
        left_dmic_d = 1'b0;
        right_dmic_d = 1'b0;
      end
    endcase
  end

  // Clamp on the output only; readback keeps the raw code
  always @* begin
    if (max_gain_field > `MAXG_CLAMP) begin
      max_gain_d = `MAXG_CLAMP + 7'h01;
    end else begin
      max_gain_d = max_gain_field;
    end
  end

  always @* begin
    if (addr_in == `OFS_BIAS_DMIC) begin
      rdata_d = bias_q;
    end else if (addr_in == `OFS_AGC_A) begin
      rdata_d = agc_a_q;
    end else if (addr_in == `OFS_AGC_B) begin
      rdata_d = agc_b_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mic_bias_output_out <= `BIAS_OFF;
    end else begin
      mic_bias_output_out <= bias_field;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      left_from_dmic_out <= 1'b0;
      right_from_dmic_out <= 1'b0;
    end else begin
      left_from_dmic_out <= left_dmic_d;
      right_from_dmic_out <= right_dmic_d;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      agc_enable_out <= 1'b0;
      target_code_out <= 3'h0;
      attack_code_out <= 2'h0;
      decay_code_out <= 2'h0;
    end else begin
      agc_enable_out <= agc_en_field;
      target_code_out <= target_field;
      attack_code_out <= attack_field;
      decay_code_out <= decay_field;
    end
  end

  // A flag only; scaling the times is left to the gain loop
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      times_exact_out <= 1'b1;
    end else begin
      times_exact_out <= ~dra_sync_q;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      max_gain_code_out <= `MAXG_CLAMP + 7'h01;
    end else begin
      max_gain_code_out <= max_gain_d;
    end
  end

  // Registered read: data follows the address by one edge
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ==== agc_cfg_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module agc_cfg_checker (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic dmic_enable_in,
  input wire logic double_rate_audio_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] mic_bias_output_out,
  input wire logic [1:0] attack_code_out,
  input wire logic [1:0] decay_code_out,
  input wire logic left_from_dmic_out,
  input wire logic right_from_dmic_out,
  input wire logic agc_enable_out,
  input wire logic times_exact_out,
  input wire logic [2:0] target_code_out,
  input wire logic [6:0] max_gain_code_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_bias; wr_en_in && addr_in == 8'h19 |-> ##2 mic_bias_output_out == $past(wdata_in[7:6], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias level");
  // Pin held long enough to clear its synchroniser
  property p_route; dmic_enable_in [*4] ##0 wr_en_in && addr_in == 8'h19 && wdata_in[5:4] != 2'h3 |-> ##2
    {left_from_dmic_out, right_from_dmic_out} == {$past(wdata_in[5:4], 2) != 2'h2, $past(wdata_in[5:4], 2) != 2'h1};
  endproperty
  a_route: assert property (p_route) else $error("mic routing");
  property p_agc; wr_en_in && addr_in == 8'h1A |-> ##2
    {agc_enable_out, target_code_out, attack_code_out, decay_code_out} == $past(wdata_in, 2);
  endproperty
  a_agc: assert property (p_agc) else $error("gain control fields");
  property p_maxg; wr_en_in && addr_in == 8'h1B |-> ##2
    max_gain_code_out == ($past(wdata_in[7:1], 2) > 7'h76 ? 7'h77 : $past(wdata_in[7:1], 2));
  endproperty
  a_maxg: assert property (p_maxg) else $error("max gain");
  property p_rd; !wr_en_in [*2] ##0 addr_in == 8'h1A |=>
    rdata_out == {agc_enable_out, target_code_out, attack_code_out, decay_code_out};
  endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_rsv; addr_in == 8'h19 |=> rdata_out[3:0] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_unm; addr_in < 8'h19 || addr_in > 8'h1B |=> rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_time; $stable(double_rate_audio_in) [*4] |-> times_exact_out == !double_rate_audio_in; endproperty
  a_time: assert property (p_time) else $error("time validity");
endmodule
bind left_agc_mic_bias_output_config agc_cfg_checker agc_cfg_checker_inst (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .wr_en_in(wr_en_in),
  .dmic_enable_in(dmic_enable_in),
  .double_rate_audio_in(double_rate_audio_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .rdata_out(rdata_out),
  .mic_bias_output_out(mic_bias_output_out),
  .attack_code_out(attack_code_out),
  .decay_code_out(decay_code_out),
  .left_from_dmic_out(left_from_dmic_out),
  .right_from_dmic_out(right_from_dmic_out),
  .agc_enable_out(agc_enable_out),
  .times_exact_out(times_exact_out),
  .target_code_out(target_code_out),
  .max_gain_code_out(max_gain_code_out)
);
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys_in,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial {wr_en_out, addr_out, wdata_out} = 17'h0;
  task acc(input logic w, input logic [7:0] a, d, output logic [7:0] s);
    s = d;
    if (a == 8'h19) s = {d[7:6], (d[5:4] == 2'h3) ? 2'h0 : d[5:4], 4'h0};
    if (a == 8'h1A && d[6:4] == 3'h7) s[6:4] = 3'h6;
    if (a == 8'h1B) s[0] = 1'b0;
    @(negedge clk_sys_in);
    wr_en_out <= w;
    addr_out <= a;
    // Idle data toggles so a stale copy never looks valid
    wdata_out <= w ? s : ~wdata_out;
  endtask
endmodule
`default_nettype wire

// ==== left_agc_mic_bias_output_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module left_agc_mic_bias_output_config_tb;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, dm = 1'b0, double_rate_audio = 1'b0, wr, l, r, en, te;
  logic [7:0] ad, wd, rd, s, a, m [3], cs [5] = '{8'hEC, 8'hEE, 8'hFE, 8'h00, 8'h02};
  logic [1:0] mb, at, dc;
  logic [2:0] tg;
  logic [6:0] mg;
  integer seed = 32'h1ad7bc74, miscompares = 0, tests_run = 0, i;
  logic [31:0] rv;
  always #10 clk_sys_in = ~clk_sys_in;
  host_model host_model_inst (.clk_sys_in(clk_sys_in), .wr_en_out(wr), .addr_out(ad), .wdata_out(wd));
  left_agc_mic_bias_output_config left_agc_mic_bias_output_config_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr_en_in(wr),
    .addr_in(ad), .wdata_in(wd), .rdata_out(rd), .dmic_enable_in(dm), .double_rate_audio_in(double_rate_audio),
    .mic_bias_output_out(mb), .left_from_dmic_out(l), .right_from_dmic_out(r), .agc_enable_out(en),
    .target_code_out(tg), .attack_code_out(at), .decay_code_out(dc), .times_exact_out(te),
    .max_gain_code_out(mg));
  task chk(input logic [7:0] seen, want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Reserved route code gives neither channel a digital mic
  function automatic logic [1:0] exp_route(input logic en_pin, input logic [1:0] code);
    exp_route = (en_pin && code != 2'h3) ? {code != 2'h2, code != 2'h1} : 2'h0;
  endfunction
  function automatic logic [6:0] exp_gain(input logic [6:0] code);
    exp_gain = (code > 7'h76) ? 7'h77 : code;
  endfunction
  task final_report;
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Three idle reads give the pin synchroniser time to settle
  task step(input logic w, input logic [7:0] a, d);
    host_model_inst.acc(w, a, d, s);
    if (w && a >= 8'h19 && a <= 8'h1B) m[a - 8'h19] = s;
    repeat (3) host_model_inst.acc(1'b0, a, 8'h00, s);
    chk(rd, (a < 8'h19 || a > 8'h1B) ? 8'h00 : m[a - 8'h19]);
    chk({mb, l, r, 4'h0}, {m[0][7:6], exp_route(dm, m[0][5:4]), 4'h0});
    chk({en, tg, at, dc}, m[1]);
    chk({te, mg}, {!double_rate_audio, exp_gain(m[2][7:1])});
  endtask
  initial begin
    #(400 * 8 * 20);
    miscompares++;
    final_report;
  end
  initial begin
    m = '{8'h00, 8'h00, 8'hFE};
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    for (i = 0; i < 3; i++) step(1'b0, 8'h19 + i[7:0], 8'h00);
    for (i = 0; i < 5; i++) step(1'b1, 8'h1B, cs[i]);
    // Digital mic held on long enough to clear the synchroniser first
    dm = 1'b1;
    step(1'b0, 8'h19, 8'h00);
    for (i = 0; i < 3; i++) step(1'b1, 8'h19, 8'h40 + i[7:0] * 8'h50);
    for (i = 0; i < 80; i++) begin
      rv = $random(seed);
      dm = rv[0];
      double_rate_audio = rv[1];
      a = 8'h18 + rv[15:8] % 8'h05;
      step(rv[2], a, rv[23:16]);
    end
    final_report;
  end
endmodule
`default_nettype wire
